/* File: shared/ctp_pkg.sv */
// constants, field layouts and carrier types of the compact timer
// assumes one system clock that doubles as the timer clock
package ctp_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int CNT_W  = 10;
  localparam int AW     = 3;
  localparam int DW     = 16;
  localparam int CTRL_W = 12;
  localparam int LEN_W  = 11;

  // ************************************************************
  // register offsets (word index on the plain register port)
  // ************************************************************
  localparam logic [AW-1:0] ADDR_CTRL   = 3'h0;
  localparam logic [AW-1:0] ADDR_CMPA   = 3'h1;
  localparam logic [AW-1:0] ADDR_COUNT  = 3'h2;
  localparam logic [AW-1:0] ADDR_STATUS = 3'h3;

  // ************************************************************
  // status bit positions, reset values, counting constants
  // ************************************************************
  localparam int STAT_A_POS = 0;
  localparam int STAT_P_POS = 1;

  localparam logic [CNT_W-1:0] CMPA_RST = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3FF;
  localparam logic [6:0]       PRD_LOW  = 7'h00;
  localparam logic [LEN_W-1:0] LEN_FULL = 11'h400;

  // ************************************************************
  // modes and output-function codes
  // ************************************************************
  typedef enum logic [1:0] {
    CTP_MODE_CMP = 2'b00,
    CTP_MODE_UND = 2'b01,
    CTP_MODE_PWM = 2'b10,
    CTP_MODE_TMR = 2'b11
  } ctp_mode_e;

  localparam logic [1:0] IO_HOLD   = 2'b00;
  localparam logic [1:0] IO_LOW    = 2'b01;
  localparam logic [1:0] IO_HIGH   = 2'b10;
  localparam logic [1:0] IO_TOGGLE = 2'b11;
  localparam logic [1:0] PWM_OFF   = 2'b00;
  localparam logic [1:0] PWM_ON    = 2'b01;
  localparam logic [1:0] PWM_WAVE  = 2'b10;

  // ************************************************************
  // carriers
  // ************************************************************
  // control word, bit 11 down to bit 0, as seen at ADDR_CTRL
  typedef struct packed {
    logic        clear_select;
    logic        duplex_select;
    logic        output_polarity;
    logic        output_control;
    logic [1:0]  output_function;
    ctp_mode_e   mode_select;
    logic [2:0]  period_value;
    logic        timer_enable;
  } ctp_ctrl_s;

  localparam ctp_ctrl_s CTRL_RST = '{default: '0, mode_select: CTP_MODE_CMP};

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } ctp_bus_s;

endpackage

/* File: hdl/ctp_cmp.sv */
// one equality comparator of the timer against a reference count
// assumes the caller hands in the counter's next value
`timescale 1ns/1ps
module ctp_cmp #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] cnt_next,   // counter value about to be reached
  input  wire logic [W-1:0] ref_val,    // reference count
  input  wire logic         zero_ok,    // a zero reference may match (at wrap)
  output logic              hit         // match pulse
);

  assign hit = (cnt_next == ref_val) && ((ref_val != '0) || zero_ok);

endmodule // ctp_cmp

/* File: hdl/ctp_pin.sv */
// output pin logic: compare actions, pwm levels, polarity, enable
// assumes match events and pwm level come from the timer core
`timescale 1ns/1ps
module ctp_pin (
  input  wire logic      clk,          // system clock
  input  wire logic      rst_n,        // synchronous reset, active low
  input  ctp_pkg::ctp_ctrl_s ctrl,     // control word
  input  wire logic      en_rise,      // enable just rose
  input  wire logic      a_evt,        // compare-A flag generated
  input  wire logic      pwm_active,   // pwm waveform in active phase
  output logic           pin_out,      // pin level
  output logic           pin_oe        // pin driven
);
  import ctp_pkg::*;

  typedef struct packed {
    logic lvl;
    logic out;
    logic oe;
  } ctp_pin_s;

  ctp_pin_s s_ff;
  ctp_pin_s nxt_s;
  logic     act;

  always_comb begin
    nxt_s = s_ff;
    act   = 1'b0;
    if (en_rise) begin
      nxt_s.lvl = ctrl.output_control;
    end else if (a_evt && ctrl.mode_select == CTP_MODE_CMP) begin
      case (ctrl.output_function)
        IO_LOW:    nxt_s.lvl = 1'b0;
        IO_HIGH:   nxt_s.lvl = 1'b1;
        IO_TOGGLE: nxt_s.lvl = ~s_ff.lvl;
        default:   nxt_s.lvl = s_ff.lvl;
      endcase
    end
    case (ctrl.output_function)
      PWM_OFF:  act = 1'b0;
      PWM_ON:   act = 1'b1;
      PWM_WAVE: act = pwm_active;
      default:  act = 1'b0;
    endcase
    case (ctrl.mode_select)
      CTP_MODE_CMP: begin
        nxt_s.out = nxt_s.lvl ^ ctrl.output_polarity;
        nxt_s.oe  = 1'b1;
      end
      CTP_MODE_PWM: begin
        // polarity applied after the active-level choice
        nxt_s.out = (act ? ctrl.output_control : ~ctrl.output_control)
                    ^ ctrl.output_polarity;
        nxt_s.oe  = 1'b1;
      end
      default: begin
        nxt_s.out = 1'b0;
        nxt_s.oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pin_out = s_ff.out;
  assign pin_oe  = s_ff.oe;

endmodule // ctp_pin

/* File: hdl/ctp_timer.sv */
// compact 10-bit timer with compare, timer/counter and pwm modes
// assumes a register master on the plain port and one 100 MHz clock
//
// Overview of operation
// - mode code 00 selects compare output
// - clear-select low: period match clears, zero wraps
// - clear-select low: raise both match flags
// - clear-select high: compare-A clears, no period flag
// - compare-A zero: wrap at 3FF, no flag
// - pin changes only on compare-A flag or enable rise
// - compare-A match drives high, low or toggles
// - function codes: hold, low, high, toggle
// - enable rise loads pin initial level
// - mode 11 counts like compare, pin unused
// - mode 10 generates fixed-period variable-duty pwm
// - pwm ignores clear-select, uses duplex-select
// - duplex low: period value sets period
// - duplex high: compare-A sets period
// - duty not below period gives full duty
// - pwm raises both flags on matches
// - function field enables wave or forces level
// - pwm codes: inactive, active, wave; polarity
// - forced levels keep counting and flags running
// - polarity bit inverts pin level
// - period value compares counter bits 9..7
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module ctp_timer (
  input  wire logic               CLK_SYS,     // system clock, 100 MHz
  input  wire logic               RST_N,       // synchronous reset, active low
  input  ctp_pkg::ctp_bus_s       BUS_REQ,     // address, data, strobes
  output logic [ctp_pkg::DW-1:0]  RD_DATA,     // read data, cycle after strobe
  output logic                    TMR_OUT,     // timer output pin level
  output logic                    TMR_OUT_EN,  // timer output pin driven
  output logic                    FLAG_A,      // compare-A match request
  output logic                    FLAG_P       // period match request
);
  import ctp_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    ctp_ctrl_s         ctrl;
    logic [CNT_W-1:0]  cmpa;
    logic [CNT_W-1:0]  cnt;
    logic              en_prev;
    logic              flag_a;
    logic              flag_p;
    logic [DW-1:0]     rdata;
  } ctp_core_s;

  localparam ctp_core_s CORE_RST = '{
    ctrl:    CTRL_RST,
    cmpa:    CMPA_RST,
    cnt:     CNT_ZERO,
    en_prev: 1'b0,
    flag_a:  1'b0,
    flag_p:  1'b0,
    rdata:   '0
  };

  ctp_core_s         s_ff;
  ctp_core_s         nxt_s;

  logic              en_rise;
  logic              counting;
  logic              pwm_mode;
  logic              cmp_like;
  logic [CNT_W-1:0]  cnt_inc;
  logic [CNT_W-1:0]  prd_ref;
  logic              a_hit;
  logic              p_hit;
  logic              a_evt;
  logic              p_evt;
  logic              clr_cnt;
  logic [LEN_W-1:0]  prd_len;
  logic [LEN_W-1:0]  cmpa_len;
  logic [LEN_W-1:0]  period_len;
  logic [LEN_W-1:0]  duty_len;
  logic              pwm_active;
  logic              clr_a;
  logic              clr_p;

  // ************************************************************
  // comparators
  // ************************************************************
  assign en_rise  = s_ff.ctrl.timer_enable & ~s_ff.en_prev;
  assign counting = s_ff.ctrl.timer_enable & s_ff.en_prev;
  assign pwm_mode = (s_ff.ctrl.mode_select == CTP_MODE_PWM);
  // mode 01 is undefined: it counts like compare mode with the pin idle
  assign cmp_like = ~pwm_mode;
  assign cnt_inc  = s_ff.cnt + CNT_ONE;
  // period value sits on the top three counter bits only
  assign prd_ref  = {s_ff.ctrl.period_value, PRD_LOW};

  // a zero compare-A value never flags outside pwm (overflow instead)
  ctp_cmp #(
    .W (CNT_W)
  ) u_cmp_a (
    .cnt_next (cnt_inc),
    .ref_val  (s_ff.cmpa),
    .zero_ok  (pwm_mode),
    .hit      (a_hit)
  );

  // a zero period value matches at the wrap, i.e. 1024 clocks
  ctp_cmp #(
    .W (CNT_W)
  ) u_cmp_p (
    .cnt_next (cnt_inc),
    .ref_val  (prd_ref),
    .zero_ok  (1'b1),
    .hit      (p_hit)
  );

  // ************************************************************
  // clear and flag selection
  // ************************************************************
  always_comb begin
    a_evt   = 1'b0;
    p_evt   = 1'b0;
    clr_cnt = 1'b0;
    if (counting) begin
      if (pwm_mode) begin
        a_evt   = a_hit;
        p_evt   = p_hit;
        // clear-select is not looked at here
        clr_cnt = s_ff.ctrl.duplex_select ? a_hit : p_hit;
      end else if (s_ff.ctrl.clear_select) begin
        a_evt   = a_hit;
        clr_cnt = a_hit;
      end else begin
        a_evt   = a_hit;
        p_evt   = p_hit;
        clr_cnt = p_hit;
      end
    end
  end

  // ************************************************************
  // pwm duty and period
  // ************************************************************
  assign prd_len  = (s_ff.ctrl.period_value == 3'h0) ? LEN_FULL : {1'b0, prd_ref};
  assign cmpa_len = (s_ff.cmpa == CNT_ZERO) ? LEN_FULL : {1'b0, s_ff.cmpa};

  always_comb begin
    if (s_ff.ctrl.duplex_select) begin
      period_len = cmpa_len;
      duty_len   = prd_len;
    end else begin
      period_len = prd_len;
      duty_len   = {1'b0, s_ff.cmpa};
    end
  end

  // counter never passes period-1, so duty >= period stays active
  assign pwm_active = ({1'b0, s_ff.cnt} < duty_len);

  // ************************************************************
  // register port and next state
  // ************************************************************
  assign clr_a = BUS_REQ.wr && (BUS_REQ.addr == ADDR_STATUS) && BUS_REQ.wdata[STAT_A_POS];
  assign clr_p = BUS_REQ.wr && (BUS_REQ.addr == ADDR_STATUS) && BUS_REQ.wdata[STAT_P_POS];

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.en_prev = s_ff.ctrl.timer_enable;
    nxt_s.rdata   = '0;

    if (BUS_REQ.wr) begin
      if (BUS_REQ.addr == ADDR_CTRL) begin
        nxt_s.ctrl = ctp_ctrl_s'(BUS_REQ.wdata[CTRL_W-1:0]);
      end else if (BUS_REQ.addr == ADDR_CMPA) begin
        nxt_s.cmpa = BUS_REQ.wdata[CNT_W-1:0];
      end
    end

    if (BUS_REQ.rd) begin
      if (BUS_REQ.addr == ADDR_CTRL) begin
        nxt_s.rdata = {{(DW-CTRL_W){1'b0}}, s_ff.ctrl};
      end else if (BUS_REQ.addr == ADDR_CMPA) begin
        nxt_s.rdata = {{(DW-CNT_W){1'b0}}, s_ff.cmpa};
      end else if (BUS_REQ.addr == ADDR_COUNT) begin
        nxt_s.rdata = {{(DW-CNT_W){1'b0}}, s_ff.cnt};
      end else if (BUS_REQ.addr == ADDR_STATUS) begin
        nxt_s.rdata = {{(DW-2){1'b0}}, s_ff.flag_p, s_ff.flag_a};
      end else begin
        nxt_s.rdata = '0;
      end
    end

    // counter holds its value while disabled
    if (en_rise) begin
      nxt_s.cnt = CNT_ZERO;
    end else if (counting) begin
      nxt_s.cnt = clr_cnt ? CNT_ZERO : cnt_inc;
    end

    // a match in the clearing cycle is kept: set beats clear
    nxt_s.flag_a = a_evt | (s_ff.flag_a & ~clr_a);
    nxt_s.flag_p = p_evt | (s_ff.flag_p & ~clr_p);
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s_ff <= CORE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // output pin
  // ************************************************************
  ctp_pin u_pin (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .ctrl       (s_ff.ctrl),
    .en_rise    (en_rise),
    .a_evt      (a_evt),
    .pwm_active (pwm_active),
    .pin_out    (TMR_OUT),
    .pin_oe     (TMR_OUT_EN)
  );

  assign RD_DATA = s_ff.rdata;
  assign FLAG_A  = s_ff.flag_a;
  assign FLAG_P  = s_ff.flag_p;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  restart_zero_a: assert property (
    en_rise |=> (s_ff.cnt == CNT_ZERO) ##1 (s_ff.cnt == CNT_ONE || !s_ff.ctrl.timer_enable
                                           || !s_ff.en_prev || s_ff.cnt == CNT_ZERO))
    else $error("counter not restarted on enable rise");

  init_level_a: assert property (
    (en_rise && s_ff.ctrl.mode_select == CTP_MODE_CMP)
      |=> TMR_OUT == ($past(s_ff.ctrl.output_control) ^ $past(s_ff.ctrl.output_polarity)))
    else $error("pin not at initial level after enable rise");

  p_clear_a: assert property (
    (counting && cmp_like && !s_ff.ctrl.clear_select && p_hit)
      |=> (s_ff.cnt == CNT_ZERO) && s_ff.flag_p)
    else $error("period match did not clear and flag");

  a_clear_a: assert property (
    (counting && cmp_like && s_ff.ctrl.clear_select && a_hit)
      |=> (s_ff.cnt == CNT_ZERO) && s_ff.flag_a)
    else $error("compare-A match did not clear and flag");

  no_pflag_a: assert property (
    (counting && cmp_like && s_ff.ctrl.clear_select && !s_ff.flag_p) |=> !s_ff.flag_p)
    else $error("period flag raised with clear-select high");

  wrap_noflag_a: assert property (
    (counting && cmp_like && s_ff.ctrl.clear_select && s_ff.cmpa == CNT_ZERO
     && s_ff.cnt == CNT_MAX && !s_ff.flag_a)
      |=> (s_ff.cnt == CNT_ZERO) && !s_ff.flag_a)
    else $error("bad overflow with zero compare-A");

  toggle_pin_a: assert property (
    (a_evt && !en_rise && s_ff.ctrl.mode_select == CTP_MODE_CMP
     && s_ff.ctrl.output_function == IO_TOGGLE && $stable(s_ff.ctrl))
      |=> TMR_OUT != $past(TMR_OUT))
    else $error("pin did not toggle on compare-A match");

  hold_pin_a: assert property (
    (!a_evt && !en_rise && s_ff.ctrl.mode_select == CTP_MODE_CMP && $stable(s_ff.ctrl)
     && $past(s_ff.ctrl.mode_select) == CTP_MODE_CMP)
      |=> $stable(TMR_OUT))
    else $error("pin changed without compare-A flag");

  timer_idle_a: assert property (
    (s_ff.ctrl.mode_select == CTP_MODE_TMR) |=> !TMR_OUT_EN && !TMR_OUT)
    else $error("pin driven in timer/counter mode");

  pwm_clear_a: assert property (
    (counting && pwm_mode && (s_ff.ctrl.duplex_select ? a_hit : p_hit))
      |=> s_ff.cnt == CNT_ZERO)
    else $error("pwm period clear missed");

  full_duty_a: assert property (
    (pwm_mode && duty_len >= period_len && {1'b0, s_ff.cnt} < period_len) |-> pwm_active)
    else $error("duty not full when duty reaches period");

  pwm_wave_a: assert property (
    (pwm_mode && s_ff.ctrl.output_function == PWM_WAVE)
      |=> TMR_OUT == ($past(pwm_active ? s_ff.ctrl.output_control : !s_ff.ctrl.output_control)
                      ^ $past(s_ff.ctrl.output_polarity)))
    else $error("pwm pin level wrong");

  flag_sticky_a: assert property (
    (s_ff.flag_a && !clr_a) |=> s_ff.flag_a [*1])
    else $error("compare-A flag dropped without clear");

  set_wins_a: assert property (
    (p_evt && clr_p) |=> s_ff.flag_p)
    else $error("period flag lost against clear");

  // read data may only stand in the cycle after a read strobe
  read_idle_a: assert property (
    !BUS_REQ.rd |=> (RD_DATA == '0))
    else $error("read data outside the answer cycle");

  pwm_aflag_a: assert property (
    (counting && pwm_mode && a_hit) |=> s_ff.flag_a)
    else $error("pwm compare-A flag missed");

  pwm_pflag_a: assert property (
    (counting && pwm_mode && p_hit) |=> s_ff.flag_p)
    else $error("pwm period flag missed");

  pwm_forced_a: assert property (
    (pwm_mode && s_ff.ctrl.output_function == PWM_ON)
      |=> TMR_OUT == ($past(s_ff.ctrl.output_control) ^ $past(s_ff.ctrl.output_polarity)))
    else $error("forced active level wrong");

  forced_count_a: assert property (
    (counting && pwm_mode && s_ff.ctrl.output_function != PWM_WAVE && !clr_cnt)
      |=> s_ff.cnt == $past(s_ff.cnt) + CNT_ONE)
    else $error("counter stalled while pin forced");

  prd_match_a: assert property (
    p_evt |-> (cnt_inc[CNT_W-1:CNT_W-3] == s_ff.ctrl.period_value)
              && (cnt_inc[CNT_W-4:0] == PRD_LOW))
    else $error("period match off the 128-clock grid");

  undef_idle_a: assert property (
    (s_ff.ctrl.mode_select == CTP_MODE_UND) |=> !TMR_OUT_EN)
    else $error("pin driven in undefined mode");

  full_pin_a: assert property (
    (pwm_mode && s_ff.ctrl.output_function == PWM_WAVE && duty_len >= period_len
     && {1'b0, s_ff.cnt} < period_len)
      |=> TMR_OUT == ($past(s_ff.ctrl.output_control) ^ $past(s_ff.ctrl.output_polarity)))
    else $error("pin not active at full duty");

  cov_toggle: cover property (
    a_evt && s_ff.ctrl.mode_select == CTP_MODE_CMP && s_ff.ctrl.output_function == IO_TOGGLE);
  cov_pwm_period: cover property (counting && pwm_mode && p_hit ##1 s_ff.cnt == CNT_ZERO);
  cov_pwm_dpx: cover property (counting && pwm_mode && s_ff.ctrl.duplex_select && a_hit);
  cov_flag_clr: cover property (s_ff.flag_a && clr_a ##1 !s_ff.flag_a);
  cov_zero_wrap: cover property (
    counting && cmp_like && s_ff.cmpa == CNT_ZERO && s_ff.cnt == CNT_MAX);

endmodule // ctp_timer

/* File: verification/ctp_load.sv */
// pin load model: pull-down on the pin, counts cycles seen high
// assumes the timer clock and a one-cycle clear strobe from the bench
`timescale 1ns/1ps
module ctp_load (
  input  wire logic        clk,     // system clock
  input  wire logic        pin,     // pin level from the timer
  input  wire logic        pin_en,  // timer drives the pin
  input  wire logic        clr,     // restart the high count
  output logic             level,   // level seen at the load
  output logic [15:0]      hi_cnt   // cycles seen high since clear
);
  // a released pin falls to the pull-down, never keeps the last level
  assign level = pin_en ? pin : 1'b0;

  always_ff @(posedge clk) begin
    if (clr) begin
      hi_cnt <= 16'h0000;
    end else if (level) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
endmodule // ctp_load

/* File: verification/ctp_timer_tb.sv */
// self-checking bench of the compact timer: registers, compare, timer and pwm modes
// assumes ctp_load on the pin and the register map of the package
`timescale 1ns/1ps
module ctp_timer_tb;
  import ctp_pkg::*;
  logic           clk_sys;
  logic           rst_n;
  ctp_bus_s       bus_req;
  logic [DW-1:0]  rd_data;
  logic           tmr_out;
  logic           tmr_out_en;
  logic           flag_a;
  logic           flag_p;
  logic           load_clr;
  logic           load_level;
  logic [15:0]    load_hi;
  int             miscompares;
  int             num_checks;
  int             seed;
  int             n;
  logic [15:0]    v;
  logic [15:0]    r;
  logic [9:0]     c;
  logic           oc;
  logic           pin;
  ctp_ctrl_s      cw;

  ctp_timer DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .BUS_REQ(bus_req), .RD_DATA(rd_data),
    .TMR_OUT(tmr_out), .TMR_OUT_EN(tmr_out_en), .FLAG_A(flag_a), .FLAG_P(flag_p));
  ctp_load LOAD (.clk(clk_sys), .pin(tmr_out), .pin_en(tmr_out_en), .clr(load_clr),
    .level(load_level), .hi_cnt(load_hi));

  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic bw(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic br(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  // stops the timer before touching mode bits, then enables it
  task automatic start(input ctp_ctrl_s w, input logic [9:0] a);
    w.timer_enable = 1'b0;
    bw(ADDR_CTRL, {4'h0, w});
    bw(ADDR_CMPA, {6'h00, a});
    bw(ADDR_STATUS, 16'h0003);
    w.timer_enable = 1'b1;
    bw(ADDR_CTRL, {4'h0, w});
  endtask

  task automatic waitf(input logic sel_p, inout int k);
    #1;
    while ((sel_p ? flag_p : flag_a) !== 1'b1 && k < 3000) begin
      @(posedge clk_sys);
      #1 k++;
    end
  endtask

  function automatic ctp_ctrl_s pcw(input logic dpx, input logic pol, input logic ocb,
                                    input logic [1:0] io, input logic clr, input logic [2:0] prd);
    pcw = '{default: '0, mode_select: CTP_MODE_PWM};
    pcw.duplex_select = dpx;
    pcw.output_polarity = pol;
    pcw.output_control = ocb;
    pcw.output_function = io;
    pcw.clear_select = clr;
    pcw.period_value = prd;
  endfunction

  // a window of one period sees the duty whatever its phase
  task automatic pwm(input ctp_ctrl_s w, input logic [9:0] a, input int per, input int hi);
    start(w, a);
    repeat (2 * per + 4) @(posedge clk_sys);
    load_clr <= 1'b1;
    @(posedge clk_sys);
    load_clr <= 1'b0;
    repeat (per) @(posedge clk_sys);
    #1 chk("pwm high cycles", load_hi, 16'(hi));
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog, main sequence
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    conclude();
  end

  initial begin
    seed = 38274;
    rst_n = 1'b0;
    bus_req = '0;
    load_clr = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      br(3'(a), v);
      chk("reset read", v, 16'h0000);
    end
    v = 16'($random(seed));
    v[0] = 1'b0;
    bw(ADDR_CTRL, v);
    br(ADDR_CTRL, r);
    chk("ctrl readback", r, {4'h0, v[11:0]});
    @(posedge clk_sys);
    #1 chk("read data gone", rd_data, 16'h0000);
    bw(ADDR_CMPA, v);
    bw(ADDR_COUNT, 16'hFFFF);
    br(ADDR_CMPA, r);
    chk("cmpa readback", r, {6'h00, v[9:0]});
    br(ADDR_COUNT, r);
    chk("count not writable", r, 16'h0000);
    // compare mode, every output function
    for (int io = 0; io < 4; io++) begin
      c = 10'(2 + $unsigned($random(seed)) % 99);
      oc = 1'($random(seed));
      cw = '{default: '0, mode_select: CTP_MODE_CMP};
      cw.period_value = 3'h1;
      cw.output_function = 2'(io);
      cw.output_control = oc;
      start(cw, c);
      @(posedge clk_sys);
      #1 chk("pin initial", 16'(tmr_out), 16'(oc));
      n = 1;
      pin = (io == 0) ? oc : (io == 3) ? ~oc : io[1];
      waitf(1'b0, n);
      chk("a match cycle", 16'(n), 16'(c + 1));
      chk("pin after a match", 16'(tmr_out), 16'(pin));
      chk("pin enable", 16'(tmr_out_en), 16'h0001);
      waitf(1'b1, n);
      chk("p match cycle", 16'(n), 16'd129);
      chk("pin after p match", 16'(tmr_out), 16'(pin));
      chk("a flag kept", 16'(flag_a), 16'h0001);
    end
    bw(ADDR_CTRL, 16'h0000);
    br(ADDR_STATUS, r);
    chk("status both set", r, 16'h0003);
    bw(ADDR_STATUS, 16'h0003);
    br(ADDR_STATUS, r);
    chk("status cleared", r, 16'h0000);
    // clear on compare-A, period below compare-A
    cw.output_function = IO_HOLD;
    cw.clear_select = 1'b1;
    c = 10'(200 + $unsigned($random(seed)) % 100);
    start(cw, c);
    n = 0;
    waitf(1'b0, n);
    chk("a clear cycle", 16'(n), 16'(c + 1));
    repeat (300) @(posedge clk_sys);
    br(ADDR_COUNT, r);
    chk("count below a", 16'(r < 16'(c)), 16'h0001);
    chk("no p flag", 16'(flag_p), 16'h0000);
    start(cw, 10'h000);
    repeat (1100) @(posedge clk_sys);
    #1 chk("no a flag at zero", 16'(flag_a), 16'h0000);
    // timer/counter mode
    cw = '{default: '0, mode_select: CTP_MODE_TMR};
    cw.period_value = 3'h1;
    c = 10'(2 + $unsigned($random(seed)) % 99);
    start(cw, c);
    @(posedge clk_sys);
    #1 chk("pin unused", 16'(tmr_out_en), 16'h0000);
    n = 1;
    waitf(1'b0, n);
    chk("timer a cycle", 16'(n), 16'(c + 1));
    waitf(1'b1, n);
    chk("timer p cycle", 16'(n), 16'd129);
    // undefined mode code runs like timer/counter with the pin released
    cw.mode_select = CTP_MODE_UND;
    start(cw, c);
    @(posedge clk_sys);
    #1 chk("undefined mode pin", 16'(tmr_out_en), 16'h0000);
    // pwm mode
    c = 10'(1 + $unsigned($random(seed)) % 127);
    pwm(pcw(1'b0, 1'b0, 1'b1, PWM_WAVE, 1'b0, 3'h1), c, 128, int'(c));
    pwm(pcw(1'b0, 1'b0, 1'b1, PWM_WAVE, 1'b1, 3'h2), c, 256, int'(c));
    pwm(pcw(1'b0, 1'b0, 1'b1, PWM_WAVE, 1'b0, 3'h0), 10'd512, 1024, 512);
    pwm(pcw(1'b0, 1'b0, 1'b1, PWM_WAVE, 1'b0, 3'h1), 10'd200, 128, 128);
    pwm(pcw(1'b0, 1'b1, 1'b1, PWM_WAVE, 1'b0, 3'h1), c, 128, 128 - int'(c));
    pwm(pcw(1'b0, 1'b0, 1'b0, PWM_WAVE, 1'b0, 3'h1), c, 128, 128 - int'(c));
    pwm(pcw(1'b1, 1'b0, 1'b1, PWM_WAVE, 1'b0, 3'h1), 10'd300, 300, 128);
    pwm(pcw(1'b1, 1'b0, 1'b1, PWM_WAVE, 1'b0, 3'h1), 10'd100, 100, 100);
    pwm(pcw(1'b0, 1'b0, 1'b1, PWM_OFF, 1'b0, 3'h1), c, 128, 0);
    pwm(pcw(1'b0, 1'b0, 1'b1, PWM_ON, 1'b0, 3'h1), c, 128, 128);
    chk("pwm a flag", 16'(flag_a), 16'h0001);
    chk("pwm p flag forced", 16'(flag_p), 16'h0001);
    conclude();
  end
endmodule // ctp_timer_tb
